// ### rtl/jtb_tap_top.sv
// Purpose: Test access port with instruction decode and boundary chain.
// Assumes: tck is the link clock; reset is synchronous to clock.
// Notes: Update word crosses to clock by a toggle handshake.
`timescale 1ns/1ps
`include "jtb_defs.svh"
module jtb_tap_top #(
    // Arbitrary identification value; bit 0 must stay one
    parameter logic [31:0] ID_VALUE = 32'h0A5C_0001
) (
    // System clock and reset
    input wire logic clock,
    input wire logic reset,
    // Link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    // Flash register hooks, tck domain
    output logic [3:0] flash_reg_sel,
    output logic dr_capture,
    output logic dr_shift,
    output logic dr_update,
    input wire logic flash_tdo,
    // Reset pin and clock pin
    input wire logic core_rst_en,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    output logic rst_to_core,
    input wire logic ext_clock_in_pin,
    output logic xclk_to_core,
    // Weak pullup
    input wire logic core_pullup_en,
    output logic pullup_en_out,
    // Peripheral register bus, core side
    input wire logic [7:0] core_periph_addr,
    input wire logic [7:0] core_periph_wdata,
    input wire logic core_periph_wr,
    input wire logic core_periph_rd,
    input wire logic core_periph_rmw,
    output logic [7:0] periph_rdata_to_core,
    // Peripheral register bus, register side
    output logic [7:0] periph_addr_out,
    output logic [7:0] periph_wdata_out,
    output logic periph_wr_out,
    output logic periph_rd_out,
    output logic periph_rmw_out,
    input wire logic [7:0] periph_rdata,
    // Ports 0..3, bit p*8+n is pin n of port p
    input wire logic [31:0] core_port_out,
    input wire logic [31:0] core_port_oe,
    output logic [31:0] port_to_core,
    input wire logic [31:0] port_pin_in,
    output logic [31:0] port_pin_out,
    output logic [31:0] port_pin_oe_n
);
    localparam int BW = `JTB_BSR_W;
    localparam int NPIN = `JTB_NPORT * `JTB_PORT_PINS;

    function automatic jtb_pkg::jtb_tap_t tap_next(jtb_pkg::jtb_tap_t s, logic m);
        unique case (s)
            jtb_pkg::TLR: tap_next = m ? jtb_pkg::TLR : jtb_pkg::RTI;
            jtb_pkg::RTI: tap_next = m ? jtb_pkg::SEL_DR : jtb_pkg::RTI;
            jtb_pkg::SEL_DR: tap_next = m ? jtb_pkg::SEL_IR : jtb_pkg::CAP_DR;
            jtb_pkg::CAP_DR: tap_next = m ? jtb_pkg::EX1_DR : jtb_pkg::SH_DR;
            jtb_pkg::SH_DR: tap_next = m ? jtb_pkg::EX1_DR : jtb_pkg::SH_DR;
            jtb_pkg::EX1_DR: tap_next = m ? jtb_pkg::UPD_DR : jtb_pkg::PAU_DR;
            jtb_pkg::PAU_DR: tap_next = m ? jtb_pkg::EX2_DR : jtb_pkg::PAU_DR;
            jtb_pkg::EX2_DR: tap_next = m ? jtb_pkg::UPD_DR : jtb_pkg::SH_DR;
            jtb_pkg::UPD_DR: tap_next = m ? jtb_pkg::SEL_DR : jtb_pkg::RTI;
            jtb_pkg::SEL_IR: tap_next = m ? jtb_pkg::TLR : jtb_pkg::CAP_IR;
            jtb_pkg::CAP_IR: tap_next = m ? jtb_pkg::EX1_IR : jtb_pkg::SH_IR;
            jtb_pkg::SH_IR: tap_next = m ? jtb_pkg::EX1_IR : jtb_pkg::SH_IR;
            jtb_pkg::EX1_IR: tap_next = m ? jtb_pkg::UPD_IR : jtb_pkg::PAU_IR;
            jtb_pkg::PAU_IR: tap_next = m ? jtb_pkg::EX2_IR : jtb_pkg::PAU_IR;
            jtb_pkg::EX2_IR: tap_next = m ? jtb_pkg::UPD_IR : jtb_pkg::SH_IR;
            jtb_pkg::UPD_IR: tap_next = m ? jtb_pkg::SEL_DR : jtb_pkg::RTI;
        endcase
    endfunction

    function automatic jtb_pkg::jtb_instr_t decode_ir(logic [`JTB_IR_W-1:0] code);
        case (code)
            `JTB_OP_EXTEST: decode_ir = jtb_pkg::I_EXTEST;
            `JTB_OP_SAMPLE: decode_ir = jtb_pkg::I_SAMPLE;
            `JTB_OP_IDCODE: decode_ir = jtb_pkg::I_IDCODE;
            `JTB_OP_FCON: decode_ir = jtb_pkg::I_FCON;
            `JTB_OP_FDAT: decode_ir = jtb_pkg::I_FDAT;
            `JTB_OP_FADR: decode_ir = jtb_pkg::I_FADR;
            `JTB_OP_FSCL: decode_ir = jtb_pkg::I_FSCL;
            default: decode_ir = jtb_pkg::I_BYPASS;
        endcase
    endfunction

    // Crossings
    jtb_sync_if #(.W(NPIN + 2)) pin_if ();
    jtb_sync_if #(.W(1)) rst_if ();
    jtb_sync_if #(.W(BW)) cap_if ();
    jtb_sync_if #(.W(2)) ctl_if ();

    jtb_sync u_pin_sync (.clk(clock), .s(pin_if.sync));
    jtb_sync u_rst_sync (.clk(tck), .s(rst_if.sync));
    jtb_sync u_cap_sync (.clk(tck), .s(cap_if.sync));
    jtb_sync u_ctl_sync (.clk(clock), .s(ctl_if.sync));

    // Link domain state
    jtb_pkg::jtb_tap_t state_q;
    jtb_pkg::jtb_instr_t instr_q;
    logic [`JTB_IR_W-1:0] ir_sh_q;
    logic [BW-1:0] bsr_sh_q;
    logic [BW-1:0] bsr_upd_q;
    logic [`JTB_ID_W-1:0] id_sh_q;
    logic bypass_q;
    logic upd_tgl_q;
    logic ext_tck_q;
    logic [3:0] flash_sel_q;
    logic rst_tck;
    logic bsr_sel;
    logic dr_out;

    // System domain state
    logic [BW-1:0] cap_vec_q;
    logic [BW-1:0] upd_sys_q;
    logic tgl_seen_q;
    logic ext_sys;
    logic rst_pin_s;
    logic xclk_s;
    logic [31:0] port_pin_s;

    assign rst_if.d = reset;
    assign rst_tck = rst_if.q[0];
    assign bsr_sel = (instr_q == jtb_pkg::I_EXTEST) || (instr_q == jtb_pkg::I_SAMPLE);

    always_ff @(posedge tck) begin
        if (rst_tck) begin
            state_q <= jtb_pkg::TLR;
        end else begin
            state_q <= tap_next(state_q, tms);
        end
    end

    // Instruction register
    always_ff @(posedge tck) begin
        if (rst_tck || state_q == jtb_pkg::TLR) begin
            ir_sh_q <= `JTB_IR_RESET;
            instr_q <= jtb_pkg::I_IDCODE;
        end else begin
            unique case (state_q)
                jtb_pkg::CAP_IR: ir_sh_q <= `JTB_IR_CAPTURE;
                jtb_pkg::SH_IR: ir_sh_q <= {tdi, ir_sh_q[`JTB_IR_W-1:1]};
                jtb_pkg::UPD_IR: instr_q <= decode_ir(ir_sh_q);
                default: ;
            endcase
        end
    end

    // Loaded with the instruction so a host may stop tck right after idle
    always_ff @(posedge tck) begin
        if (rst_tck || state_q == jtb_pkg::TLR) begin
            flash_sel_q <= 4'h0;
        end else if (state_q == jtb_pkg::UPD_IR) begin
            flash_sel_q[0] <= (decode_ir(ir_sh_q) == jtb_pkg::I_FCON);
            flash_sel_q[1] <= (decode_ir(ir_sh_q) == jtb_pkg::I_FDAT);
            flash_sel_q[2] <= (decode_ir(ir_sh_q) == jtb_pkg::I_FADR);
            flash_sel_q[3] <= (decode_ir(ir_sh_q) == jtb_pkg::I_FSCL);
        end
    end

    // Boundary chain shift stage
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            bsr_sh_q <= '0;
        end else if (bsr_sel && state_q == jtb_pkg::CAP_DR) begin
            bsr_sh_q <= cap_if.q;
        end else if (bsr_sel && state_q == jtb_pkg::SH_DR) begin
            bsr_sh_q <= {tdi, bsr_sh_q[BW-1:1]};
        end
    end

    // Preload is allowed in both modes; only external test applies it
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            bsr_upd_q <= '0;
            upd_tgl_q <= 1'b0;
        end else if (bsr_sel && state_q == jtb_pkg::UPD_DR) begin
            bsr_upd_q <= bsr_sh_q;
            upd_tgl_q <= ~upd_tgl_q;
        end
    end

    always_ff @(posedge tck) begin
        if (rst_tck || state_q == jtb_pkg::TLR) begin
            ext_tck_q <= 1'b0;
        end else if (state_q == jtb_pkg::UPD_IR) begin
            ext_tck_q <= (decode_ir(ir_sh_q) == jtb_pkg::I_EXTEST);
        end
    end

    // Identification and bypass
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            id_sh_q <= '0;
            bypass_q <= 1'b0;
        end else if (state_q == jtb_pkg::CAP_DR) begin
            id_sh_q <= ID_VALUE;
            bypass_q <= 1'b0;
        end else if (state_q == jtb_pkg::SH_DR) begin
            id_sh_q <= {tdi, id_sh_q[`JTB_ID_W-1:1]};
            bypass_q <= tdi;
        end
    end

    always_comb begin
        unique case (instr_q)
            jtb_pkg::I_EXTEST, jtb_pkg::I_SAMPLE: dr_out = bsr_sh_q[0];
            jtb_pkg::I_IDCODE: dr_out = id_sh_q[0];
            jtb_pkg::I_BYPASS: dr_out = bypass_q;
            jtb_pkg::I_FCON, jtb_pkg::I_FDAT, jtb_pkg::I_FADR,
            jtb_pkg::I_FSCL: dr_out = flash_tdo;
        endcase
    end

    // Output changes on the falling edge so the host samples it mid-bit
    always_ff @(negedge tck) begin
        if (rst_tck) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            tdo <= (state_q == jtb_pkg::SH_IR) ? ir_sh_q[0] : dr_out;
            tdo_oe_n <= !(state_q == jtb_pkg::SH_IR || state_q == jtb_pkg::SH_DR);
        end
    end

    assign flash_reg_sel = flash_sel_q;
    assign dr_capture = (flash_sel_q != 4'h0) && (state_q == jtb_pkg::CAP_DR);
    assign dr_shift = (flash_sel_q != 4'h0) && (state_q == jtb_pkg::SH_DR);
    assign dr_update = (flash_sel_q != 4'h0) && (state_q == jtb_pkg::UPD_DR);

    // System domain: pins pass two flops first
    assign pin_if.d = {rst_pin_in, ext_clock_in_pin, port_pin_in};
    assign rst_pin_s = pin_if.q[NPIN + 1];
    assign xclk_s = pin_if.q[NPIN];
    assign port_pin_s = pin_if.q[NPIN-1:0];

    assign ctl_if.d = {upd_tgl_q, ext_tck_q};
    assign ext_sys = ctl_if.q[0];

    // Capture word registered here so the link side sees clean levels
    always_ff @(posedge clock) begin
        if (reset) begin
            cap_vec_q <= '0;
        end else begin
            cap_vec_q[`JTB_B_RST_OE] <= core_rst_en;
            cap_vec_q[`JTB_B_RST_IO] <= rst_pin_s;
            cap_vec_q[`JTB_B_XCLK] <= xclk_s;
            cap_vec_q[`JTB_B_PULL] <= core_pullup_en;
            cap_vec_q[`JTB_B_ADDR +: 8] <= core_periph_addr;
            cap_vec_q[`JTB_B_DATA +: 8] <= periph_rdata;
            cap_vec_q[`JTB_B_WR] <= core_periph_wr;
            cap_vec_q[`JTB_B_RD] <= core_periph_rd;
            cap_vec_q[`JTB_B_RMW] <= core_periph_rmw;
            for (int i = 0; i < NPIN; i++) begin
                cap_vec_q[`JTB_B_PORT0 + 2*i] <= core_port_oe[i];
                cap_vec_q[`JTB_B_PORT0 + 2*i + 1] <= port_pin_s[i];
            end
        end
    end
    assign cap_if.d = cap_vec_q;

    // Update word is held still in tck domain long after the toggle lands
    always_ff @(posedge clock) begin
        if (reset) begin
            tgl_seen_q <= 1'b0;
            upd_sys_q <= '0;
        end else begin
            tgl_seen_q <= ctl_if.q[1];
            if (ctl_if.q[1] != tgl_seen_q) begin
                upd_sys_q <= bsr_upd_q;
            end
        end
    end

    // Pin and bus drivers
    always_ff @(posedge clock) begin
        if (reset) begin
            rst_pin_oe_n <= 1'b1;
            rst_pin_out <= 1'b0;
            pullup_en_out <= 1'b0;
            periph_addr_out <= 8'h00;
            periph_wdata_out <= 8'h00;
            periph_wr_out <= 1'b0;
            periph_rd_out <= 1'b0;
            periph_rmw_out <= 1'b0;
            port_pin_out <= 32'h0000_0000;
            port_pin_oe_n <= 32'hFFFF_FFFF;
        end else if (ext_sys) begin
            rst_pin_oe_n <= !upd_sys_q[`JTB_B_RST_OE];
            rst_pin_out <= upd_sys_q[`JTB_B_RST_IO];
            // Clock-pin cell drives nothing on update
            pullup_en_out <= upd_sys_q[`JTB_B_PULL];
            periph_addr_out <= upd_sys_q[`JTB_B_ADDR +: 8];
            periph_wdata_out <= upd_sys_q[`JTB_B_DATA +: 8];
            periph_wr_out <= upd_sys_q[`JTB_B_WR];
            periph_rd_out <= upd_sys_q[`JTB_B_RD];
            periph_rmw_out <= upd_sys_q[`JTB_B_RMW];
            for (int i = 0; i < NPIN; i++) begin
                port_pin_oe_n[i] <= !upd_sys_q[`JTB_B_PORT0 + 2*i];
                port_pin_out[i] <= upd_sys_q[`JTB_B_PORT0 + 2*i + 1];
            end
        end else begin
            // Sample mode leaves functional paths alone
            rst_pin_oe_n <= !core_rst_en;
            rst_pin_out <= 1'b0;
            pullup_en_out <= core_pullup_en;
            periph_addr_out <= core_periph_addr;
            periph_wdata_out <= core_periph_wdata;
            periph_wr_out <= core_periph_wr;
            periph_rd_out <= core_periph_rd;
            periph_rmw_out <= core_periph_rmw;
            port_pin_out <= core_port_out;
            port_pin_oe_n <= ~core_port_oe;
        end
    end

    // Inputs into on-chip logic
    always_ff @(posedge clock) begin
        if (reset) begin
            rst_to_core <= 1'b1;
            xclk_to_core <= 1'b1;
            port_to_core <= 32'hFFFF_FFFF;
            periph_rdata_to_core <= 8'hFF;
        end else if (ext_sys) begin
            rst_to_core <= 1'b1;
            xclk_to_core <= 1'b1;
            port_to_core <= 32'hFFFF_FFFF;
            periph_rdata_to_core <= 8'hFF;
        end else begin
            rst_to_core <= rst_pin_s;
            xclk_to_core <= xclk_s;
            port_to_core <= port_pin_s;
            periph_rdata_to_core <= periph_rdata;
        end
    end
endmodule // jtb_tap_top

// ### rtl/jtb_defs.svh
// Purpose: Constants for the boundary-scan test access port.
// Assumes: Included by bare name; definitions only.
// Notes: Bit positions index the 87-bit boundary chain.
// Notes on behaviour
// - Instruction register is 16 bits, fully shifted.
// - Code 0000h selects boundary chain, external test.
// - Code 0002h selects boundary chain, sample/preload.
// - Code 0004h selects 32-bit identification register.
// - Code FFFFh places one-bit bypass between TDI/TDO.
// - Code 0082h selects flash control register.
// - Code 0083h selects flash data register.
// - Code 0084h selects flash address register.
// - Code 0085h selects flash prescale register.
// - Boundary chain is an 87-bit shift register.
// - External test captures and updates; sample captures and preloads the update stage.
// - External test forces all on-chip inputs to one.
// - Bits 0,1 carry reset enable and reset pin.
// - Bit 2 captures clock pin; update ignored.
// - Bit 3 carries the weak-pullup enable.
// - Bits 4-11 carry peripheral address bus.
// - Bits 12-19 capture read data, drive write data.
// - Bits 20-22 carry write, read, read-modify-write strobes.
// - Port 0 pairs at bits 23-38, enable first.
// - Port 2 pairs at bits 55-70, enable first.
// - Port 3 pairs at bits 71-86, enable first.
`ifndef JTB_DEFS_SVH
`define JTB_DEFS_SVH

`define JTB_IR_W 16
`define JTB_IR_RESET 16'h0004
`define JTB_IR_CAPTURE 16'h0001
`define JTB_OP_EXTEST 16'h0000
`define JTB_OP_SAMPLE 16'h0002
`define JTB_OP_IDCODE 16'h0004
`define JTB_OP_BYPASS 16'hFFFF
`define JTB_OP_FCON 16'h0082
`define JTB_OP_FDAT 16'h0083
`define JTB_OP_FADR 16'h0084
`define JTB_OP_FSCL 16'h0085

`define JTB_BSR_W 87
`define JTB_ID_W 32
`define JTB_B_RST_OE 0
`define JTB_B_RST_IO 1
`define JTB_B_XCLK 2
`define JTB_B_PULL 3
`define JTB_B_ADDR 4
`define JTB_B_DATA 12
`define JTB_B_WR 20
`define JTB_B_RD 21
`define JTB_B_RMW 22
`define JTB_B_PORT0 23
`define JTB_PORT_SPAN 16
`define JTB_NPORT 4
`define JTB_PORT_PINS 8

`endif

// ### rtl/jtb_pkg.sv
// Purpose: Types for the boundary-scan test access port.
// Assumes: Used with scoped names only.
// Notes: TAP states follow the standard sixteen-state controller.
package jtb_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jtb_tap_t;

    typedef enum logic [2:0] {
        I_EXTEST, I_SAMPLE, I_IDCODE, I_BYPASS, I_FCON, I_FDAT, I_FADR, I_FSCL
    } jtb_instr_t;
endpackage

// ### rtl/jtb_sync_if.sv
// Purpose: Carries one word into a two-flop synchroniser.
// Assumes: Source word is registered in its own domain.
// Notes: Each bit is an independent level.
`timescale 1ns/1ps
interface jtb_sync_if #(parameter int W = 1);
    logic [W-1:0] d;
    logic [W-1:0] q;
    modport user (output d, input q);
    modport sync (input d, output q);
endinterface

// ### rtl/jtb_sync.sv
// Purpose: Two-flop synchroniser for independent levels.
// Assumes: Destination clock on clk.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps
module jtb_sync (
    // Destination clock
    input wire logic clk,
    // Word in and out
    jtb_sync_if.sync s
);
    logic [$bits(s.d)-1:0] meta_q;

    always_ff @(posedge clk) begin
        meta_q <= s.d;
        s.q <= meta_q;
    end
endmodule // jtb_sync

// ### tb/jtb_tap_sva.sv
// Purpose: Port assertions for the test access port.
// Assumes: rst_to_core is low only outside external test.
// Notes: Link checks use tck, pass-through checks use clock.
`timescale 1ns/1ps
module jtb_tap_sva (
    // Clocks and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic tck,
    // Link side
    input wire logic tdo_oe_n,
    input wire logic [3:0] flash_reg_sel,
    input wire logic dr_capture,
    input wire logic dr_shift,
    input wire logic dr_update,
    // Core side
    input wire logic rst_to_core,
    input wire logic core_rst_en,
    input wire logic rst_pin_oe_n,
    input wire logic [7:0] core_periph_addr,
    input wire logic [7:0] periph_addr_out,
    input wire logic core_periph_wr,
    input wire logic periph_wr_out
);
    sel_onehot_a: assert property (@(posedge tck) disable iff (reset)
        $onehot0(flash_reg_sel)) else $error("flash select not one-hot");
    shift_sel_a: assert property (@(posedge tck) disable iff (reset)
        dr_shift |-> flash_reg_sel != 4'h0) else $error("shift without flash select");
    update_sel_a: assert property (@(posedge tck) disable iff (reset)
        dr_update |-> flash_reg_sel != 4'h0) else $error("update without flash select");
    capture_once_a: assert property (@(posedge tck) disable iff (reset)
        dr_capture |=> !dr_capture && !dr_update) else $error("capture not single");
    shift_drive_a: assert property (@(posedge tck) disable iff (reset)
        dr_shift |-> !tdo_oe_n) else $error("tdo idle while shifting");
    fn_addr_a: assert property (@(posedge clock) disable iff (reset)
        !rst_to_core && !$past(reset) |-> periph_addr_out == $past(core_periph_addr))
        else $error("address not passed through");
    fn_wr_a: assert property (@(posedge clock) disable iff (reset)
        !rst_to_core && !$past(reset) |-> periph_wr_out == $past(core_periph_wr))
        else $error("write strobe not passed through");
    fn_rst_oe_a: assert property (@(posedge clock) disable iff (reset)
        !rst_to_core && !$past(reset) |-> rst_pin_oe_n == !$past(core_rst_en))
        else $error("reset pin enable not passed through");
    cover property (@(posedge tck) dr_update && flash_reg_sel[3]);
    cover property (@(posedge clock) rst_to_core && !periph_wr_out);
    cover property (@(posedge clock) !rst_to_core && periph_wr_out);
endmodule // jtb_tap_sva

bind jtb_tap_top jtb_tap_sva u_jtb_tap_sva (
    .clock, .reset, .tck, .tdo_oe_n, .flash_reg_sel, .dr_capture, .dr_shift, .dr_update,
    .rst_to_core, .core_rst_en, .rst_pin_oe_n, .core_periph_addr, .periph_addr_out,
    .core_periph_wr, .periph_wr_out
);

// ### tb/jtb_host.sv
// Purpose: Link host model for the test access port.
// Assumes: Device samples on tck rise, moves tdo on tck fall.
// Notes: tck stands low between frames.
`timescale 1ns/1ps
module jtb_host (
    // Link to the device
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        {tck, tms, tdi} = 3'h2;
    end
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #3;
        tck = 1'b1;
        o = tdo;
        #3;
        tck = 1'b0;
    endtask
    // Unused tdi toggles so a stale level never passes for data
    task automatic idle(input logic m);
        logic o;
        step(m, ~tdi, o);
    endtask
    task automatic tap_reset();
        repeat (6) idle(1'b1);
        idle(1'b0);
    endtask
    // From idle to idle, n bits LSB first
    task automatic scan(input logic ir, input int n, input logic [86:0] din,
                        output logic [86:0] dout);
        logic o;
        dout = '0;
        idle(1'b1);
        if (ir) idle(1'b1);
        idle(1'b0);
        idle(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        idle(1'b1);
        idle(1'b0);
    endtask
endmodule // jtb_host

// ### tb/jtb_tap_top_tb.sv
// Purpose: Self-checking bench for the test access port.
// Assumes: Host model drives the link; bench drives core and pins.
// Notes: Fixed waits cover the crossing latencies.
`timescale 1ns/1ps
module jtb_tap_top_tb;
    // Arbitrary identification value, bit 0 set
    localparam logic [31:0] ID_VAL = 32'h1357_9BDF;
    localparam logic [86:0] PRE = {32'hA5A5_5A5A, 32'h0FF0_C33C, 23'h55AA3};
    logic clock, reset, tck, tms, tdi, tdo, tdo_oe_n, rst_pin_out, rst_pin_oe_n;
    logic dr_capture, dr_shift, dr_update, rst_to_core, xclk_to_core, pullup_en_out;
    logic periph_wr_out, periph_rd_out, periph_rmw_out;
    logic [3:0] flash_reg_sel;
    logic [7:0] periph_rdata_to_core, periph_addr_out, periph_wdata_out;
    logic [31:0] port_to_core, port_pin_out, port_pin_oe_n;
    logic [86:0] got;
    logic flash_tdo = 1'b0, core_rst_en = 1'b1, rst_pin_in = 1'b0, ext_clock_in_pin = 1'b1;
    logic core_pullup_en = 1'b1, core_periph_wr = 1'b1, core_periph_rd = 1'b0;
    logic core_periph_rmw = 1'b1;
    logic [7:0] core_periph_addr = 8'hC5, core_periph_wdata = 8'h3A, periph_rdata = 8'h69;
    logic [31:0] core_port_out = 32'h5AF0_3C96, core_port_oe = 32'hC3A5_0FF1;
    logic [31:0] port_pin_in = 32'h96E1_4B2D;
    int fails = 0;
    int checks_done = 0;
    jtb_tap_top #(.ID_VALUE(ID_VAL)) u_jtb_tap_top (
        .clock, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .flash_reg_sel, .dr_capture,
        .dr_shift, .dr_update, .flash_tdo, .core_rst_en, .rst_pin_in, .rst_pin_out,
        .rst_pin_oe_n, .rst_to_core, .ext_clock_in_pin, .xclk_to_core, .core_pullup_en,
        .pullup_en_out, .core_periph_addr, .core_periph_wdata, .core_periph_wr,
        .core_periph_rd, .core_periph_rmw, .periph_rdata_to_core, .periph_addr_out,
        .periph_wdata_out, .periph_wr_out, .periph_rd_out, .periph_rmw_out, .periph_rdata,
        .core_port_out, .core_port_oe, .port_to_core, .port_pin_in, .port_pin_out,
        .port_pin_oe_n
    );
    jtb_host u_jtb_host (.tck, .tms, .tdi, .tdo);
    task automatic check(input string what, input logic [86:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic load_ir(input logic [15:0] code);
        u_jtb_host.scan(1'b1, 16, {71'h0, code}, got);
        check("ir capture", got[15:0], 16'h0001);
    endtask
    function automatic logic [86:0] cap_vec();
        logic [86:0] v = '0;
        v[22:0] = {core_periph_rmw, core_periph_rd, core_periph_wr, periph_rdata,
            core_periph_addr, core_pullup_en, ext_clock_in_pin, rst_pin_in, core_rst_en};
        for (int i = 0; i < 32; i++) v[24 + 2 * i -: 2] = {port_pin_in[i], core_port_oe[i]};
        return v;
    endfunction
    task automatic check_pins(input logic [86:0] v);
        check("rst pull", {pullup_en_out, rst_pin_out, rst_pin_oe_n}, {v[3], v[1], !v[0]});
        check("bus", {periph_rmw_out, periph_rd_out, periph_wr_out, periph_wdata_out,
            periph_addr_out}, v[22:4]);
        for (int i = 0; i < 32; i++) check("pin", {port_pin_out[i], port_pin_oe_n[i]},
            {v[24 + 2 * i], !v[23 + 2 * i]});
    endtask
    task automatic t_idcode();
        u_jtb_host.scan(1'b0, 32, '0, got);
        check("id after reset", got[31:0], ID_VAL);
        load_ir(16'h0004);
        u_jtb_host.scan(1'b0, 33, '0, got);
        check("id length", got[32:0], {1'b0, ID_VAL});
    endtask
    task automatic t_bypass();
        logic [15:0] codes [4] = '{16'hFFFF, 16'h1234, 16'h0001, 16'h0086};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            u_jtb_host.scan(1'b0, 9, 87'h1A5, got);
            check("bypass", {flash_reg_sel, got[8:0]}, 13'h014A);
        end
    endtask
    task automatic t_flash();
        for (int k = 0; k < 4; k++) begin
            @(negedge clock) flash_tdo = k[0];
            load_ir(16'h0082 + 16'(k));
            check("flash sel", flash_reg_sel, 4'h1 << k);
            u_jtb_host.scan(1'b0, 4, '0, got);
            check("flash out", got[3:0], {4{k[0]}});
        end
    endtask
    task automatic t_sample();
        @(negedge clock);
        port_pin_in = 32'h1E2D_3C4B;
        core_periph_addr = 8'h5C;
        repeat (10) @(negedge clock);
        load_ir(16'h0002);
        u_jtb_host.scan(1'b0, 87, PRE, got);
        check("smp capture", got, cap_vec());
        repeat (8) @(negedge clock);
        check("smp pins", {port_pin_out, port_pin_oe_n}, {core_port_out, ~core_port_oe});
        check("smp core", {periph_addr_out, port_to_core}, {core_periph_addr, port_pin_in});
        check("smp in", {periph_rdata_to_core, xclk_to_core, rst_to_core},
            {periph_rdata, ext_clock_in_pin, rst_pin_in});
    endtask
    task automatic t_extest();
        load_ir(16'h0000);
        repeat (8) @(negedge clock);
        check_pins(PRE);
        check("forced", {port_to_core, periph_rdata_to_core, rst_to_core, xclk_to_core},
            42'h3FF_FFFF_FFFF);
        u_jtb_host.scan(1'b0, 87, ~PRE, got);
        check("ext capture", got, cap_vec());
        repeat (8) @(negedge clock);
        check_pins(~PRE);
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        fork
            repeat (6) @(negedge clock);
            u_jtb_host.tap_reset();
        join
        reset = 1'b0;
        u_jtb_host.tap_reset();
        t_idcode();
        t_bypass();
        t_flash();
        t_sample();
        t_extest();
        stop_test();
    end
endmodule // jtb_tap_top_tb
